// file: rtl/itc_counter.sv
// One channel of a programmable interval counter behind AXI4-Lite.
// Assumes cnt_clk and gate_in are synchronous to core_clk and much slower.
`timescale 1ns/1ps
module itc_counter #(
  parameter int AW = 4,
  parameter int CW = 16
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  input  wire logic          cnt_clk,
  input  wire logic          gate_in,
  output logic               timer_out,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready
);

  typedef struct packed {
    itc_pkg::itc_cst_t cst;
    logic [2:0]        mode;
    logic              bcd;
    logic [1:0]        acc;
    logic [CW-1:0]     cr;
    logic [CW-1:0]     ce;
    logic              out;
    logic              null_cnt;
    logic              msb_next;
    logic              fire;
    logic              extra;
    logic              clk_q;
    logic              gate_q;
    logic              seen;
    logic              gate_lvl;
    logic              trig_cap;
    logic              trig_smp;
    logic              aw_got;
    logic [AW-1:0]     aw_addr;
    logic              w_got;
    logic [7:0]        w_byte;
    logic              w_lane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } itc_state_t;

  itc_state_t r;
  itc_state_t next_r;

  logic rise;
  logic fall;
  logic gate_edge;
  logic wr_fire;
  logic wr_ctrl;
  logic wr_cnt;
  logic rd_fire;
  logic periodic;

  // Single decrement, binary or decimal; zero wraps to the top value
  function automatic logic [CW-1:0] dec1(input logic [CW-1:0] v, input logic bcd);
    logic [CW-1:0] t;
    logic          b;
    t = v - {{(CW-1){1'b0}}, 1'b1};
    if (bcd)
    begin
      t = v;
      b = 1'b1;
      for (int i = 0; i < CW / 4; i++)
      begin
        if (b)
        begin
          if (t[4*i+:4] == 4'h0)
          begin
            t[4*i+:4] = 4'h9;
          end
          else
          begin
            t[4*i+:4] = t[4*i+:4] - 4'h1;
            b = 1'b0;
          end
        end
      end
    end
    return t;
  endfunction

  // Counter clock edges, pulses only count once a rise was seen
  assign rise      = cnt_clk & ~r.clk_q;
  assign fall      = ~cnt_clk & r.clk_q & r.seen;
  assign gate_edge = gate_in & ~r.gate_q;
  assign periodic  = (r.mode == itc_pkg::MODE_RATE) || (r.mode == itc_pkg::MODE_SQUARE);

  // Bus handshakes; a held response blocks new requests
  assign s_axi_awready = ~r.aw_got & ~r.bvalid;
  assign s_axi_wready  = ~r.w_got & ~r.bvalid;
  assign s_axi_arready = ~r.rvalid;
  assign wr_fire       = r.aw_got & r.w_got & ~r.bvalid;
  assign wr_ctrl       = wr_fire & r.w_lane & (r.aw_addr == itc_pkg::OFS_CONTROL);
  assign wr_cnt        = wr_fire & r.w_lane & (r.aw_addr == itc_pkg::OFS_COUNT);
  assign rd_fire       = s_axi_arvalid & ~r.rvalid;

  // Outputs straight from state flops
  assign timer_out    = r.out;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp  = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata  = r.rdata;
  assign s_axi_rresp  = r.rresp;

  // Whole next state in one place
  always_comb
  begin
    logic [CW-1:0] ld;
    logic [2:0]    m;
    ld     = (r.mode == itc_pkg::MODE_SQUARE) ? {r.cr[CW-1:1], 1'b0} : r.cr;
    m      = 3'h0;
    next_r = r;
    next_r.clk_q  = cnt_clk;
    next_r.gate_q = gate_in;

    // Gate level and trigger flop sampled on the rise; set beats clear
    if (rise)
    begin
      next_r.seen     = 1'b1;
      next_r.gate_lvl = gate_in;
      next_r.trig_smp = r.trig_cap;
    end
    next_r.trig_cap = (r.trig_cap & ~rise) | gate_edge;

    // Load and decrement on the fall
    if (fall)
    begin
      next_r.seen     = 1'b0;
      next_r.trig_smp = 1'b0;
      case (r.cst)
        itc_pkg::ST_LOAD:
        begin
          // First pulse after the write loads without decrementing
          next_r.ce       = ld;
          next_r.cst      = itc_pkg::ST_RUN;
          next_r.null_cnt = 1'b0;
          next_r.fire     = 1'b1;
          next_r.extra    = 1'b0;
        end
        itc_pkg::ST_ARMED:
        begin
          if (r.trig_smp)
          begin
            next_r.ce       = r.cr;
            next_r.cst      = itc_pkg::ST_RUN;
            next_r.null_cnt = 1'b0;
            next_r.fire     = 1'b1;
            if (r.mode == itc_pkg::MODE_ONESHOT)
            begin
              next_r.out = 1'b0;
            end
          end
        end
        itc_pkg::ST_RUN:
        begin
          if (r.trig_smp && (r.mode != itc_pkg::MODE_TCINT)
              && (r.mode != itc_pkg::MODE_SWSTRB))
          begin
            // Retrigger picks up whatever count is held now
            next_r.ce       = ld;
            next_r.null_cnt = 1'b0;
            next_r.fire     = 1'b1;
            next_r.extra    = 1'b0;
            next_r.out      = (r.mode != itc_pkg::MODE_ONESHOT);
          end
          else
          begin
            case (r.mode)
              itc_pkg::MODE_TCINT:
              begin
                if (r.gate_lvl)
                begin
                  next_r.ce = dec1(r.ce, r.bcd);
                  if (r.ce == {{(CW-1){1'b0}}, 1'b1})
                  begin
                    next_r.out = 1'b1;
                  end
                end
              end
              itc_pkg::MODE_ONESHOT:
              begin
                next_r.ce = dec1(r.ce, r.bcd);
                if (r.ce == {{(CW-1){1'b0}}, 1'b1})
                begin
                  next_r.out = 1'b1;
                end
              end
              itc_pkg::MODE_RATE:
              begin
                if (r.gate_lvl)
                begin
                  if (r.ce == {{(CW-1){1'b0}}, 1'b1})
                  begin
                    // End of period takes a pending new count
                    next_r.ce       = r.cr;
                    next_r.null_cnt = 1'b0;
                    next_r.out      = 1'b1;
                  end
                  else
                  begin
                    next_r.ce  = dec1(r.ce, r.bcd);
                    next_r.out = (r.ce != {{(CW-2){1'b0}}, 2'h2});
                  end
                end
              end
              itc_pkg::MODE_SQUARE:
              begin
                if (r.gate_lvl)
                begin
                  if (r.extra)
                  begin
                    // Odd count: high half runs one pulse longer
                    next_r.out      = 1'b0;
                    next_r.ce       = ld;
                    next_r.extra    = 1'b0;
                    next_r.null_cnt = 1'b0;
                  end
                  else if (r.ce == {{(CW-2){1'b0}}, 2'h2})
                  begin
                    if (r.cr[0] && r.out)
                    begin
                      next_r.extra = 1'b1;
                      next_r.ce    = {CW{1'b0}};
                    end
                    else
                    begin
                      next_r.out      = ~r.out;
                      next_r.ce       = ld;
                      next_r.null_cnt = 1'b0;
                    end
                  end
                  else
                  begin
                    next_r.ce = dec1(dec1(r.ce, r.bcd), r.bcd);
                  end
                end
              end
              itc_pkg::MODE_SWSTRB,
              itc_pkg::MODE_HWSTRB:
              begin
                if (r.gate_lvl || (r.mode == itc_pkg::MODE_HWSTRB))
                begin
                  next_r.ce  = dec1(r.ce, r.bcd);
                  next_r.out = 1'b1;
                  // Strobe only once per load, not at every wrap
                  if (r.fire && (r.ce == {{(CW-1){1'b0}}, 1'b1}))
                  begin
                    next_r.out  = 1'b0;
                    next_r.fire = 1'b0;
                  end
                end
              end
              default:
              begin
                next_r.out = 1'b1;
              end
            endcase
          end
        end
        default:
        begin
          next_r.cst = r.cst;
        end
      endcase
    end

    // Low gate forces the periodic modes high without a pulse
    if (periodic && !gate_in)
    begin
      next_r.out = 1'b1;
    end

    // Write address and data taken independently
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_r.aw_got  = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_r.w_got  = 1'b1;
      next_r.w_byte = s_axi_wdata[7:0];
      next_r.w_lane = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      next_r.bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      next_r.aw_got = 1'b0;
      next_r.w_got  = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp  = ((r.aw_addr == itc_pkg::OFS_CONTROL) || (r.aw_addr == itc_pkg::OFS_COUNT)
                       || (r.aw_addr == itc_pkg::OFS_STATUS)) ?
                      itc_pkg::RESP_OKAY : itc_pkg::RESP_SLVERR;
    end

    // Control word: reset control logic and set output at once
    if (wr_ctrl)
    begin
      m = r.w_byte[itc_pkg::CTL_MODE_LSB+:3];
      if (m[1])
      begin
        m[2] = 1'b0;
      end
      next_r.mode     = m;
      next_r.bcd      = r.w_byte[itc_pkg::CTL_BCD_BIT];
      next_r.acc      = r.w_byte[itc_pkg::CTL_ACC_LSB+:2];
      next_r.cst      = itc_pkg::ST_IDLE;
      next_r.out      = (m != itc_pkg::MODE_TCINT);
      next_r.null_cnt = 1'b1;
      next_r.msb_next = 1'b0;
      next_r.fire     = 1'b0;
      next_r.extra    = 1'b0;
      next_r.trig_cap = gate_edge; // Stale trigger dropped; a fresh edge still wins
      next_r.trig_smp = 1'b0;
      if (next_r.acc == 2'h0)
      begin
        next_r.acc = itc_pkg::ACC_RESET;
      end
    end

    // Count bytes into the count holding register
    if (wr_cnt)
    begin
      if ((r.acc == itc_pkg::ACC_BOTH) && !r.msb_next)
      begin
        next_r.cr[7:0]  = r.w_byte;
        next_r.msb_next = 1'b1;
        if (r.mode == itc_pkg::MODE_TCINT)
        begin
          next_r.cst = itc_pkg::ST_IDLE;
          next_r.out = 1'b0;
        end
      end
      else
      begin
        next_r.msb_next = 1'b0;
        next_r.null_cnt = 1'b1;
        if (r.acc == itc_pkg::ACC_LSB)
        begin
          next_r.cr = {{(CW-8){1'b0}}, r.w_byte};
        end
        else if (r.acc == itc_pkg::ACC_MSB)
        begin
          next_r.cr = {r.w_byte, 8'h00};
        end
        else
        begin
          next_r.cr[15:8] = r.w_byte;
        end
        case (r.mode)
          itc_pkg::MODE_TCINT,
          itc_pkg::MODE_SWSTRB:
          begin
            next_r.cst = itc_pkg::ST_LOAD;
            next_r.out = (r.mode != itc_pkg::MODE_TCINT);
          end
          itc_pkg::MODE_ONESHOT,
          itc_pkg::MODE_HWSTRB:
          begin
            if (r.cst == itc_pkg::ST_IDLE)
            begin
              next_r.cst = itc_pkg::ST_ARMED;
            end
          end
          default:
          begin
            if (r.cst == itc_pkg::ST_IDLE)
            begin
              next_r.cst = itc_pkg::ST_LOAD;
            end
          end
        endcase
      end
    end

    // Reads answer one cycle after the address
    if (s_axi_rvalid && s_axi_rready)
    begin
      next_r.rvalid = 1'b0;
    end
    if (rd_fire)
    begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = itc_pkg::RESP_OKAY;
      next_r.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        itc_pkg::OFS_CONTROL:
        begin
          next_r.rdata[6:0] = {1'b0, r.acc, r.bcd, r.mode};
        end
        itc_pkg::OFS_COUNT:
        begin
          next_r.rdata[CW-1:0] = r.ce;
        end
        itc_pkg::OFS_STATUS:
        begin
          next_r.rdata[itc_pkg::STS_OUT_BIT]  = r.out;
          next_r.rdata[itc_pkg::STS_NULL_BIT] = r.null_cnt;
        end
        default:
        begin
          next_r.rresp = itc_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      r          <= '0;
      r.cst      <= itc_pkg::ST_IDLE;
      r.acc      <= itc_pkg::ACC_RESET;
      r.out      <= itc_pkg::OUT_RESET;
      r.null_cnt <= 1'b1;
      r.gate_q   <= 1'b1; // A gate already high at reset is no trigger
    end
    else if (clk_en)
    begin
      r <= next_r;
    end
  end

  // Checks on the counting engine and the bus
  ctl_mode0_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && wr_ctrl && (r.w_byte[2:0] == 3'h0) |=> !timer_out)
    else $error("output not low after mode 0 control word");
  gate_no_out_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && (r.mode == itc_pkg::MODE_TCINT) && !fall && !wr_fire |=> $stable(timer_out))
    else $error("mode 0 output moved without a pulse");
  rate_gate_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && (r.mode == itc_pkg::MODE_RATE) && !gate_in && !wr_fire |=> timer_out)
    else $error("mode 2 output not forced high");
  sq_gate_high_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && (r.mode == itc_pkg::MODE_SQUARE) && !gate_in && !wr_fire |=> timer_out)
    else $error("mode 3 output not forced high");
  trig_capture_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && gate_edge |=> r.trig_cap)
    else $error("trigger edge lost");
  load_on_fall_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && (r.cst == itc_pkg::ST_LOAD) && fall && !wr_fire
    |=> (r.cst == itc_pkg::ST_RUN) && (r.ce == $past(r.cr) || r.mode == itc_pkg::MODE_SQUARE))
    else $error("count not loaded on pulse");
  rate_reload_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && (r.mode == itc_pkg::MODE_RATE) && (r.cst == itc_pkg::ST_RUN) && fall
    && r.gate_lvl && !r.trig_smp && (r.ce == 16'h0001) && !wr_fire
    |=> (r.ce == $past(r.cr)) && timer_out)
    else $error("mode 2 reload wrong");
  count_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clk_en && !fall && !wr_fire |=> $stable(r.ce))
    else $error("count moved without falling edge");
  bresp_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rvalid_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");

  // Main scenarios
  tc_rise_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    (r.mode == itc_pkg::MODE_TCINT) && $rose(timer_out));
  sq_toggle_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    (r.mode == itc_pkg::MODE_SQUARE) && r.gate_lvl && $fell(timer_out));
  shot_trig_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    (r.mode == itc_pkg::MODE_ONESHOT) && (r.cst == itc_pkg::ST_ARMED) ##1 !timer_out);
  hw_strobe_c: cover property (@(posedge core_clk) disable iff (sys_rst)
    (r.mode == itc_pkg::MODE_HWSTRB) && $fell(timer_out));

endmodule

// file: rtl/itc_pkg.sv
// Constants, offsets and state codes of one interval counter channel.
// Assumes an AXI4-Lite master and a synchronous counter clock and gate.
package itc_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_COUNT   = 4'h4;
  localparam logic [3:0] OFS_STATUS  = 4'h8;
  // Control word fields
  localparam int CTL_MODE_LSB = 0;
  localparam int CTL_BCD_BIT  = 3;
  localparam int CTL_ACC_LSB  = 4;
  // Status fields
  localparam int STS_OUT_BIT  = 0;
  localparam int STS_NULL_BIT = 1;
  // Count access formats
  localparam logic [1:0] ACC_LSB  = 2'h1;
  localparam logic [1:0] ACC_MSB  = 2'h2;
  localparam logic [1:0] ACC_BOTH = 2'h3;
  // Operating modes
  localparam logic [2:0] MODE_TCINT   = 3'h0;
  localparam logic [2:0] MODE_ONESHOT = 3'h1;
  localparam logic [2:0] MODE_RATE    = 3'h2;
  localparam logic [2:0] MODE_SQUARE  = 3'h3;
  localparam logic [2:0] MODE_SWSTRB  = 3'h4;
  localparam logic [2:0] MODE_HWSTRB  = 3'h5;
  // Reset values
  localparam logic [1:0] ACC_RESET = 2'h1;
  localparam logic       OUT_RESET = 1'b1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Counting engine states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_LOAD  = 4'h2,
    ST_RUN   = 4'h4,
    ST_ARMED = 4'h8
  } itc_cst_t;
endpackage

// file: verification/itc_link_model.sv
// Far-side model: counter clock source and gate driver for one channel.
// Assumes the bench holds pulse_req high for as many pulses as it wants.
`timescale 1ns/1ps
module itc_link_model (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic pulse_req,
  input  wire logic gate_req,
  output logic      cnt_clk,
  output logic      gate_in,
  output logic      pulse_done
);
  logic [1:0] phase;
  // Two cycles low, two high; clock stands low between requests
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      phase <= 2'h0;
    else if (pulse_req || phase != 2'h0)
      phase <= phase + 2'h1;
  end
  assign cnt_clk    = phase[1]; // Rise then fall per pulse
  assign pulse_done = (phase == 2'h3); // Wrap to zero is the falling edge
  // Bench drops the gate in mode 2 while the count stands at one, output low
  always_ff @(posedge core_clk)
  begin
    gate_in <= gate_req;
  end
endmodule

// file: verification/interval_counter_modes_test.sv
// Bench for one counter channel: AXI4-Lite host tasks and a read scoreboard.
// Assumes the link model supplies counter clock pulses and the gate level.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module interval_counter_modes_test;
  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        preq = 1'b0;
  logic        gate_req = 1'b1;
  logic        run_en = 1'b1;
  logic        cnt_clk, gate_in, pdone, timer_out;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [65:0] exp_q[$];
  logic [65:0] e;
  int          bad_count = 0, cmp_count = 0, n, hi, j;
  integer      seed = 32'h5531;

  itc_link_model i_link (.core_clk(core_clk), .sys_rst(sys_rst), .pulse_req(preq),
    .gate_req(gate_req), .cnt_clk(cnt_clk), .gate_in(gate_in), .pulse_done(pdone));
  itc_counter #(.AW(4), .CW(16)) i_dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .clk_en(run_en), .cnt_clk(cnt_clk), .gate_in(gate_in), .timer_out(timer_out),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  always #10 core_clk = ~core_clk;

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Ready is seen as it stood at the edge; each half drops once taken
    do
    begin
      @(posedge core_clk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
    // Idle edge so a following call never re-raises bready in the same step
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] d,
                    input logic [1:0] er);
    exp_q.push_back({er, m, d});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    rready <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic so(input logic v);
    rd(itc_pkg::OFS_STATUS, 32'h1, {31'h0, v}, itc_pkg::RESP_OKAY);
  endtask

  task automatic ctl(input logic [2:0] m, input logic [1:0] a);
    wr(itc_pkg::OFS_CONTROL, {26'h0, a, 1'b0, m}, itc_pkg::RESP_OKAY);
  endtask

  task automatic cnt(input int v);
    wr(itc_pkg::OFS_COUNT, 32'(v), itc_pkg::RESP_OKAY);
  endtask

  // Pulse request stays high across a burst so it is never set twice in one step
  task automatic pulses(input int k);
    preq <= 1'b1;
    repeat (k)
    begin
      do @(posedge core_clk); while (pdone !== 1'b1);
    end
    preq <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask

  // Short gate pulse between clock rises must still be caught
  task automatic trig();
    gate_req <= 1'b1;
    repeat (2) @(posedge core_clk);
    gate_req <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic results();
    if (bad_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Scoreboard: oldest note against each read answer
  always @(posedge core_clk)
  begin
    if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      `CHK("rdata", e[31:0], rdata & e[63:32])
      `CHK("rresp", e[65:64], rresp)
    end
  end

  // Watchdog sized well above the expected run
  initial
  begin
    repeat (30000) @(posedge core_clk);
    bad_count++;
    results();
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    so(itc_pkg::OUT_RESET);
    rd(4'hc, 32'hffffffff, 32'h0, itc_pkg::RESP_SLVERR);
    wr(4'hc, 32'h0, itc_pkg::RESP_SLVERR);
    // Count kept at two or more so mode 2 never sees one
    n = 2 + ($unsigned($random(seed)) % 5);
    ctl(itc_pkg::MODE_TCINT, itc_pkg::ACC_LSB);
    so(1'b0);
    cnt(n);
    pulses(n);
    so(1'b0);
    pulses(1);
    so(1'b1);
    ctl(itc_pkg::MODE_TCINT, itc_pkg::ACC_BOTH);
    cnt(n);
    cnt(0);
    pulses(n + 1);
    so(1'b1);
    cnt(n);
    so(1'b0);
    ctl(itc_pkg::MODE_RATE, itc_pkg::ACC_LSB);
    cnt(n);
    pulses(n - 1);
    so(1'b1);
    pulses(1);
    so(1'b0);
    pulses(n);
    so(1'b0);
    gate_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    so(1'b1);
    ctl(itc_pkg::MODE_TCINT, itc_pkg::ACC_LSB);
    cnt(n);
    pulses(3);
    rd(itc_pkg::OFS_COUNT, 32'hffff, 32'(n), itc_pkg::RESP_OKAY);
    gate_req <= 1'b1;
    pulses(n - 1);
    so(1'b0);
    pulses(1);
    so(1'b1);
    ctl(itc_pkg::MODE_SWSTRB, itc_pkg::ACC_LSB);
    cnt(n);
    pulses(n);
    so(1'b1);
    pulses(1);
    so(1'b0);
    pulses(1);
    so(1'b1);
    ctl(itc_pkg::MODE_SWSTRB, itc_pkg::ACC_BOTH);
    cnt(n);
    cnt(0);
    pulses(2);
    cnt(n);
    pulses(1);
    rd(itc_pkg::OFS_COUNT, 32'hffff, 32'(n - 2), itc_pkg::RESP_OKAY);
    cnt(0);
    pulses(n);
    so(1'b1);
    pulses(1);
    so(1'b0);
    for (j = 4; j < 6; j++)
    begin
      ctl(itc_pkg::MODE_SQUARE, itc_pkg::ACC_LSB);
      cnt(j);
      pulses(1);
      hi = 0;
      repeat (2 * j)
      begin
        pulses(1);
        hi += (timer_out === 1'b1) ? 1 : 0;
      end
      `CHK("high_pulses", j + (j % 2), hi)
    end
    gate_req <= 1'b0;
    ctl(itc_pkg::MODE_ONESHOT, itc_pkg::ACC_LSB);
    cnt(n);
    so(1'b1);
    trig();
    pulses(n);
    so(1'b0);
    pulses(1);
    so(1'b1);
    ctl(itc_pkg::MODE_HWSTRB, itc_pkg::ACC_LSB);
    cnt(n);
    pulses(n + 2);
    so(1'b1);
    trig();
    pulses(n);
    so(1'b1);
    pulses(1);
    so(1'b0);
    pulses(1);
    so(1'b1);
    rd(itc_pkg::OFS_COUNT, 32'hffff, 32'hffff, itc_pkg::RESP_OKAY);
    // Pulses while the clock enable is low must leave no trace
    run_en <= 1'b0;
    pulses(2);
    run_en <= 1'b1;
    rd(itc_pkg::OFS_COUNT, 32'hffff, 32'hffff, itc_pkg::RESP_OKAY);
    pulses(1);
    rd(itc_pkg::OFS_COUNT, 32'hffff, 32'hfffe, itc_pkg::RESP_OKAY);
    repeat (4) @(posedge core_clk);
    results();
  end
endmodule
